/* design/mfp_code_decode.v */
// decodes a 7-bit shifted significand code: value = code[3:0] << code[6:4]
// pure combinational; used for the three parameter fields
`timescale 1ns/1ps
module mfp_code_decode (
  // code in
  input wire [6:0] code,
  // decoded value out
  output wire [10:0] value
);
  assign value = {7'h00, code[3:0]} << code[6:4];
endmodule

/* design/mfp_param_bank.v */
// feedback and motor-parameter register bank, byte-wide register port
// assumes every input, control bits too, comes from logic on clk;
// the nvm image is steady while a reload is requested
// Summary of operation
// - speed readout is a 16-bit count, hertz equals count over ten.
// - period readout is 16 bits in 10 us units, high byte first.
// - bemf constant readout is twice digital constant, high byte first.
// - startup angle byte is sensed position plus advance angle.
// - rail level byte: volts equal code times 30 over 256.
// - active rate request byte, all ones means full scale.
// - smoothed request readout shows bits eight down to one.
// - fault byte bits 5..0 flag stalls, no motor, faults; 7:6 zero.
// - pwm rate select: clear 25 kHz, set 50 kHz.
// - resistance code: significand 3:0 shifted by 6:4.
// - loop correction span: clear full cycle, set half cycle.
// - velocity constant code: significand 3:0 shifted by 6:4.
// - advance select: clear fixed time, set speed/supply dependent.
// - advance time is 2.5 us times decoded advance field.
// - config writes take effect only with write enable set.
// - nvm reload copies nonvolatile image into config registers.
`timescale 1ns/1ps
`include "mfp_regs.vh"
module mfp_param_bank (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  // control bits
  input wire cfg_write_enable,
  input wire nvm_reload,
  // nonvolatile image
  input wire [7:0] nvm_cfg1,
  input wire [7:0] nvm_cfg2,
  input wire [7:0] nvm_cfg3,
  // measurements from motor control
  input wire [15:0] rotor_rate_readout,
  input wire [15:0] electrical_cycle_time,
  input wire [15:0] measured_bemf_constant,
  input wire [7:0] startup_rotor_angle,
  input wire [7:0] input_rail_level,
  input wire [7:0] rate_request_value,
  input wire [8:0] smoothed_rate_request_value,
  input wire stall_in_closed_loop,
  input wire stall_in_open_loop,
  input wire no_motor_flag,
  input wire bemf_constant_fault,
  input wire rate_fault,
  input wire current_limit_stall,
  // decoded configuration
  output reg pwm_rate_select_q,
  output reg [15:0] pwm_period_cyc_q,
  output reg [10:0] phase_resistance_q,
  output reg loop_correction_span_q,
  output reg [10:0] velocity_constant_q,
  output reg advance_timing_select_q,
  output reg [16:0] advance_interval_cyc_q
);
  reg [7:0] cfg1_q;
  reg [7:0] cfg2_q;
  reg [7:0] cfg3_q;
  reg [7:0] rate_lo_q;
  reg [7:0] cyc_lo_q;
  reg [7:0] bemf_lo_q;
  reg [7:0] rdata_d;
  reg [5:0] faults_q;
  wire [10:0] res_dec;
  wire [10:0] kt_dec;
  wire [10:0] adv_dec;
  wire [5:0] faults_in;

  // write strobes and read arms
  wire cfg_wr_ok;
  wire wr_cfg1;
  wire wr_cfg2;
  wire wr_cfg3;
  wire rd_rate_hi;
  wire rd_cyc_hi;
  wire rd_bemf_hi;

  // next values of the decoded outputs
  wire pwm_fast;
  wire [15:0] pwm_period_d;
  wire [16:0] adv_cyc_d;

  // cycle counts at the 20 MHz clock, sized to their targets
  localparam [15:0] PWM_FAST_DIV = `MFP_PWM_FAST_DIV;
  localparam [15:0] PWM_SLOW_DIV = `MFP_PWM_SLOW_DIV;
  localparam [16:0] ADV_STEP_CYC = `MFP_ADV_STEP_CYC;

  assign faults_in = {stall_in_closed_loop, stall_in_open_loop,
    no_motor_flag, bemf_constant_fault, rate_fault, current_limit_stall};

  // a reload in the same cycle wins over a host write
  assign cfg_wr_ok = reg_wr && cfg_write_enable && !nvm_reload;
  assign wr_cfg1 = cfg_wr_ok && (reg_addr == `MFP_ADDR_CFG1);
  assign wr_cfg2 = cfg_wr_ok && (reg_addr == `MFP_ADDR_CFG2);
  assign wr_cfg3 = cfg_wr_ok && (reg_addr == `MFP_ADDR_CFG3);

  // high-byte reads arm the low-byte snapshots
  assign rd_rate_hi = reg_rd && (reg_addr == `MFP_ADDR_RATE_HI);
  assign rd_cyc_hi = reg_rd && (reg_addr == `MFP_ADDR_CYC_HI);
  assign rd_bemf_hi = reg_rd && (reg_addr == `MFP_ADDR_BEMF_HI);

  // divider of the selected pwm rate
  assign pwm_fast = cfg1_q[`MFP_MODE_BIT];
  assign pwm_period_d = pwm_fast ? PWM_FAST_DIV : PWM_SLOW_DIV;

  // decoded field times the 2.5 us step; fits 17 bits
  assign adv_cyc_d = {6'h00, adv_dec} * ADV_STEP_CYC;

  mfp_code_decode u_res (
    .code(cfg1_q[6:0]),
    .value(res_dec)
  );
  mfp_code_decode u_kt (
    .code(cfg2_q[6:0]),
    .value(kt_dec)
  );
  mfp_code_decode u_adv (
    .code(cfg3_q[6:0]),
    .value(adv_dec)
  );

  // configuration registers, one per parameter byte
  // each loads the nvm image on reload, else a gated host write
  // nvm image reload
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg1_q <= `MFP_CFG1_RST;
    end else if (nvm_reload) begin
      cfg1_q <= nvm_cfg1;
    end else if (wr_cfg1) begin
      cfg1_q <= reg_wdata;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg2_q <= `MFP_CFG2_RST;
    end else if (nvm_reload) begin
      cfg2_q <= nvm_cfg2;
    end else if (wr_cfg2) begin
      cfg2_q <= reg_wdata;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg3_q <= `MFP_CFG3_RST;
    end else if (nvm_reload) begin
      cfg3_q <= nvm_cfg3;
    end else if (wr_cfg3) begin
      cfg3_q <= reg_wdata;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      faults_q <= 6'h00;
    end else begin
      faults_q <= faults_in;
    end
  end

  // low-byte snapshots taken when the high byte is read
  // speed low byte snapshot
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rate_lo_q <= 8'h00;
    end else if (rd_rate_hi) begin
      rate_lo_q <= rotor_rate_readout[7:0];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_lo_q <= 8'h00;
    end else if (rd_cyc_hi) begin
      cyc_lo_q <= electrical_cycle_time[7:0];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bemf_lo_q <= 8'h00;
    end else if (rd_bemf_hi) begin
      bemf_lo_q <= measured_bemf_constant[7:0];
    end
  end

  // read mux
  always @* begin
    case (reg_addr)
      `MFP_ADDR_RATE_HI: rdata_d = rotor_rate_readout[15:8];
      `MFP_ADDR_RATE_LO: rdata_d = rate_lo_q;
      `MFP_ADDR_CYC_HI: rdata_d = electrical_cycle_time[15:8];
      `MFP_ADDR_CYC_LO: rdata_d = cyc_lo_q;
      `MFP_ADDR_BEMF_HI: rdata_d = measured_bemf_constant[15:8];
      `MFP_ADDR_BEMF_LO: rdata_d = bemf_lo_q;
      `MFP_ADDR_ANGLE: rdata_d = startup_rotor_angle;
      `MFP_ADDR_RAIL: rdata_d = input_rail_level;
      `MFP_ADDR_REQ: rdata_d = rate_request_value;
      `MFP_ADDR_SREQ: rdata_d = smoothed_rate_request_value[8:1];
      `MFP_ADDR_FAULT: rdata_d = {2'h0, faults_q} & `MFP_FAULT_MASK;
      `MFP_ADDR_CFG1: rdata_d = cfg1_q;
      `MFP_ADDR_CFG2: rdata_d = cfg2_q;
      `MFP_ADDR_CFG3: rdata_d = cfg3_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // read data holds until the next read strobe
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end
  end

  // decoded configuration outputs, each straight from a flop
  // pwm frequency select
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_rate_select_q <= 1'b0;
      pwm_period_cyc_q <= 16'h0000;
    end else begin
      pwm_rate_select_q <= pwm_fast;
      pwm_period_cyc_q <= pwm_period_d;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_resistance_q <= 11'h000;
    end else begin
      phase_resistance_q <= res_dec;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loop_correction_span_q <= 1'b0;
    end else begin
      loop_correction_span_q <= cfg2_q[`MFP_MODE_BIT];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      velocity_constant_q <= 11'h000;
    end else begin
      velocity_constant_q <= kt_dec;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      advance_timing_select_q <= 1'b0;
    end else begin
      advance_timing_select_q <= cfg3_q[`MFP_MODE_BIT];
    end
  end

  // advance in cycles
  // largest code gives 96000 cycles, inside 17 bits
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      advance_interval_cyc_q <= 17'h00000;
    end else begin
      advance_interval_cyc_q <= adv_cyc_d;
    end
  end
endmodule

/* design/mfp_regs.vh */
// register map and field constants for the motor feedback/parameter bank
// included by mfp_param_bank only; definitions only
`ifndef MFP_REGS_VH
`define MFP_REGS_VH
`define MFP_ADDR_RATE_HI 8'h11
`define MFP_ADDR_RATE_LO 8'h12
`define MFP_ADDR_CYC_HI 8'h13
`define MFP_ADDR_CYC_LO 8'h14
`define MFP_ADDR_BEMF_HI 8'h15
`define MFP_ADDR_BEMF_LO 8'h16
`define MFP_ADDR_ANGLE 8'h19
`define MFP_ADDR_RAIL 8'h1a
`define MFP_ADDR_REQ 8'h1b
`define MFP_ADDR_SREQ 8'h1c
`define MFP_ADDR_FAULT 8'h1e
`define MFP_ADDR_CFG1 8'h20
`define MFP_ADDR_CFG2 8'h21
`define MFP_ADDR_CFG3 8'h22
`define MFP_MODE_BIT 7
`define MFP_FAULT_MASK 8'h3f
`define MFP_CFG1_RST 8'h4a
`define MFP_CFG2_RST 8'h4e
`define MFP_CFG3_RST 8'h2a
`define MFP_CLK_KHZ 20000
`define MFP_PWM_SLOW_KHZ 25
`define MFP_PWM_FAST_KHZ 50
`define MFP_PWM_SLOW_DIV (`MFP_CLK_KHZ / `MFP_PWM_SLOW_KHZ)
`define MFP_PWM_FAST_DIV (`MFP_CLK_KHZ / `MFP_PWM_FAST_KHZ)
`define MFP_ADV_STEP_NS 2500
`define MFP_CLK_NS 50
`define MFP_ADV_STEP_CYC (`MFP_ADV_STEP_NS / `MFP_CLK_NS)
`endif

/* tb/mfp_host.sv */
// host model of the register port
// assumes read data is settled one cycle after the strobe edge
`timescale 1ns/1ps
module mfp_host (
  // clock
  input wire clk,
  // register port
  output reg [7:0] reg_addr = 8'h00,
  output reg reg_wr = 1'b0,
  output reg reg_rd = 1'b0,
  output reg [7:0] reg_wdata = 8'h00,
  output reg cfg_write_enable = 1'b0,
  input wire [7:0] reg_rdata_q
);
  task wr(input [7:0] a, input [7:0] d, input en);
    @(posedge clk) #2;
    {reg_addr, reg_wdata, cfg_write_enable, reg_wr} = {a, d, en, 1'b1};
    @(posedge clk) #2;
    reg_wr = 0;
    reg_wdata = ~d;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(posedge clk) #2;
    reg_addr = a;
    reg_rd = 1;
    @(posedge clk) #2;
    reg_rd = 0;
    d = reg_rdata_q;
  endtask
  task rd16(input [7:0] a, output [15:0] v);
    rd(a, v[15:8]);
    rd(a + 8'h01, v[7:0]);
  endtask
endmodule

/* tb/mfp_param_bank_chk.sv */
// assertion checker for the parameter bank
// assumes one clk domain, bound to mfp_param_bank
`timescale 1ns/1ps
module mfp_chk (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // register port, reload, first nvm image byte and speed readout
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_q,
  input wire cfg_write_enable,
  input wire nvm_reload,
  input wire [7:0] nvm_cfg1,
  input wire [15:0] rotor_rate_readout,
  // decoded outputs
  input wire pwm_rate_select_q,
  input wire [15:0] pwm_period_cyc_q,
  input wire [10:0] phase_resistance_q,
  input wire [10:0] velocity_constant_q,
  input wire [16:0] advance_interval_cyc_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  function automatic [10:0] dec(input [6:0] c);
    dec = {7'h0, c[3:0]} << c[6:4];
  endfunction
  sequence s_wr(a);
    reg_wr && cfg_write_enable && !nvm_reload && reg_addr == a ##1 1;
  endsequence
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  property p_pwm;
    $past(rst_b) |-> pwm_period_cyc_q == (pwm_rate_select_q ? 400 : 800);
  endproperty
  a_pwm: assert property (p_pwm) else $error("bad pwm period");
  property p_res;
    s_wr(8'h20) |=> phase_resistance_q == dec($past(reg_wdata, 2))
      && pwm_rate_select_q == $past(reg_wdata[7], 2);
  endproperty
  a_res: assert property (p_res) else $error("bad resistance");
  property p_kt;
    s_wr(8'h21) |=> velocity_constant_q == dec($past(reg_wdata, 2));
  endproperty
  a_kt: assert property (p_kt) else $error("bad constant");
  property p_adv;
    s_wr(8'h22) |=> advance_interval_cyc_q == dec($past(reg_wdata, 2)) * 50;
  endproperty
  a_adv: assert property (p_adv) else $error("bad advance");
  property p_lock;
    reg_wr && !cfg_write_enable && !nvm_reload |-> ##2
      $stable(phase_resistance_q) && $stable(advance_interval_cyc_q);
  endproperty
  a_lock: assert property (p_lock) else $error("write landed");
  property p_nvm;
    nvm_reload |-> ##2 phase_resistance_q == dec($past(nvm_cfg1, 2));
  endproperty
  a_nvm: assert property (p_nvm) else $error("reload missed");
  property p_rate;
    s_rd(8'h11) |=> reg_rdata_q == $past(rotor_rate_readout[15:8]);
  endproperty
  a_rate: assert property (p_rate) else $error("bad rate byte");
  property p_flt;
    s_rd(8'h1e) |=> reg_rdata_q[7:6] == 2'b00;
  endproperty
  a_flt: assert property (p_flt) else $error("fault bits 7:6 set");
endmodule
bind mfp_param_bank mfp_chk u_chk (.clk, .rst_b, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata_q, .cfg_write_enable, .nvm_reload,
  .nvm_cfg1, .rotor_rate_readout, .pwm_rate_select_q, .pwm_period_cyc_q,
  .phase_resistance_q, .velocity_constant_q, .advance_interval_cyc_q);

/* tb/motor_feedback_param_regs_test.sv */
// self-checking bench for the parameter bank
// host model drives the register port, measurements are bench regs or fixed constants
`timescale 1ns/1ps
module motor_feedback_param_regs_test;
  reg clk = 0, rst_b = 0, reload = 0;
  reg [7:0] nvm1 = 8'h33, nvm2 = 8'h96, nvm3 = 8'h17, d;
  reg [15:0] rate = 16'h01ff, cyc_time = 16'h1234, v;
  reg [5:0] flt = 6'h2d;
  wire [7:0] addr, wdata, rdata;
  wire wr, rd, en, sel, span, asel;
  wire [15:0] per;
  wire [10:0] res, kt;
  wire [16:0] adv;
  integer error_cnt = 0, total_checks = 0, cyc = 0, i;
  reg [15:0] rows [0:15];
  mfp_host u_host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .cfg_write_enable(en), .reg_rdata_q(rdata));
  mfp_param_bank uut (.clk(clk), .rst_b(rst_b), .reg_addr(addr),
    .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata_q(rdata),
    .cfg_write_enable(en), .nvm_reload(reload), .nvm_cfg1(nvm1),
    .nvm_cfg2(nvm2), .nvm_cfg3(nvm3), .rotor_rate_readout(rate),
    .electrical_cycle_time(cyc_time), .measured_bemf_constant(16'h0abc),
    .startup_rotor_angle(8'h5a), .input_rail_level(8'h67),
    .rate_request_value(8'hff), .smoothed_rate_request_value(9'h1a5),
    .stall_in_closed_loop(flt[5]), .stall_in_open_loop(flt[4]),
    .no_motor_flag(flt[3]), .bemf_constant_fault(flt[2]),
    .rate_fault(flt[1]), .current_limit_stall(flt[0]),
    .pwm_rate_select_q(sel), .pwm_period_cyc_q(per),
    .phase_resistance_q(res), .loop_correction_span_q(span),
    .velocity_constant_q(kt), .advance_timing_select_q(asel),
    .advance_interval_cyc_q(adv));
  initial forever #25 clk = ~clk;
  task chk(input [16:0] got, input [16:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      error_cnt = error_cnt + 1;
      stop_test;
    end
  end
  initial begin
    rows = '{16'h1101, 16'h12ff, 16'h1312, 16'h1434, 16'h150a, 16'h16bc,
      16'h195a, 16'h1a67, 16'h1bff, 16'h1cd2, 16'h1e2d, 16'h204a,
      16'h214e, 16'h222a, 16'h0000, 16'h1f00};
    repeat (12) @(posedge clk);
    #2 rst_b = 1;
    for (i = 0; i < 16; i = i + 1) begin
      u_host.rd(rows[i][15:8], d);
      chk(d, rows[i][7:0]);
    end
    chk({sel, per}, 17'd800);
    chk(res, 11'h0a0);
    chk({span, asel, kt}, 13'h0e0);
    chk(adv, 17'd2000);
    $display("table test done");
    u_host.wr(8'h20, 8'hf3, 1'b0);
    u_host.rd(8'h20, d);
    chk(d, 8'h4a);
    u_host.wr(8'h20, 8'hf3, 1'b1);
    u_host.wr(8'h21, 8'h85, 1'b1);
    u_host.wr(8'h22, 8'hff, 1'b1);
    @(posedge clk) #2;
    chk({sel, per}, {1'b1, 16'd400});
    chk(res, 11'h180);
    chk({span, kt}, 12'h805);
    chk(asel, 1'b1);
    chk(adv, 17'd96000);
    $display("write test done");
    @(posedge clk) #2 reload = 1;
    @(posedge clk) #2 reload = 0;
    u_host.rd(8'h20, d);
    chk(d, 8'h33);
    u_host.rd(8'h21, d);
    chk(d, 8'h96);
    u_host.rd(8'h22, d);
    chk(d, 8'h17);
    chk({span, asel, kt}, 13'h100c);
    chk(adv, 17'd700);
    u_host.rd(8'h11, d);
    rate = 16'h0203;
    u_host.rd(8'h12, d);
    chk(d, 8'hff);
    u_host.rd16(8'h11, v);
    chk(v, 16'h0203);
    u_host.rd(8'h13, d);
    chk(d, 8'h12);
    cyc_time = 16'h5678;
    u_host.rd(8'h14, d);
    chk(d, 8'h34);
    flt = 6'h12;
    u_host.rd(8'h1e, d);
    chk(d, 8'h12);
    @(posedge clk) #2 rst_b = 0;
    @(posedge clk) #2 rst_b = 1;
    chk({sel, per}, 17'd0);
    u_host.rd(8'h20, d);
    chk(d, 8'h4a);
    u_host.rd(8'h12, d);
    chk(d, 8'h00);
    chk({sel, per}, 17'd800);
    $display("reload and reset test done");
    stop_test;
  end
endmodule
